// File: rtl/clsc_pkg.sv
package clsc_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Register indexes (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_CTL     = 5'd0;
    localparam logic [4:0] REG_STAT    = 5'd1;
    localparam logic [4:0] REG_ADV     = 5'd4;
    localparam logic [4:0] REG_PAIR    = 5'd5;
    localparam logic [4:0] REG_NPTX    = 5'd7;
    localparam logic [4:0] REG_NPRX    = 5'd8;
    localparam logic [4:0] REG_GADV    = 5'd9;
    localparam logic [4:0] REG_MDIX    = 5'd18;
    localparam logic [4:0] REG_DSHIFT  = 5'd20;
    localparam logic [4:0] REG_IPD     = 5'd23;
    localparam logic [4:0] REG_INTEN   = 5'd25;
    localparam logic [4:0] REG_INTST   = 5'd26;
    localparam logic [4:0] REG_FXMDIX  = 5'd27;
    localparam logic [4:0] REG_AUXST   = 5'd28;
    localparam logic [4:0] REG_PAGE    = 5'd31;

    // ----------------------------------------------------------------
    // Page select values
    // ----------------------------------------------------------------
    localparam logic [15:0] PAGE_MAIN  = 16'h0000;
    localparam logic [15:0] PAGE_EXT   = 16'h0001;
    localparam logic [15:0] PAGE_TEST  = 16'h2a30;

    // ----------------------------------------------------------------
    // Reset values and fixed words
    // ----------------------------------------------------------------
    localparam logic [15:0] CTL_RST    = 16'h1140;
    localparam logic [15:0] ADV_RST    = 16'h01e1;
    localparam logic [15:0] GADV_RST   = 16'h0300;
    localparam logic [15:0] NPTX_RST   = 16'h2001;
    localparam logic [15:0] STAT_BASE  = 16'h7949;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTL_SPD_LSB = 13;
    localparam int CTL_AN_EN   = 12;
    localparam int CTL_AN_RST  = 9;
    localparam int CTL_DUPLEX  = 8;
    localparam int CTL_SPD_MSB = 6;
    localparam int STAT_LINK   = 2;
    localparam int GADV_MS_MAN = 12;
    localparam int GADV_MS_VAL = 11;
    localparam int MDIX_XSEL   = 7;
    localparam int MDIX_AUTOD  = 5;
    localparam int MDIX_POLD   = 4;
    localparam int PAIR_LSB    = 3;
    localparam int DS_EN       = 4;
    localparam int DS_CNT_LSB  = 2;
    localparam int DS_STAT     = 1;
    localparam int IPD_EN      = 10;
    localparam int IPD_ST_LSB  = 8;
    localparam int INT_PIN_EN  = 15;
    localparam int INT_IPD     = 9;
    localparam int FX_MDIX_DIS = 15;
    localparam int GADV_1000F  = 9;
    localparam int GADV_1000H  = 8;
    localparam int ADV_ABIL_LSB = 5;
    localparam int ABIL_GIG_LSB = 4;

    localparam logic [1:0] PAIR_STRAIGHT = 2'b10;
    localparam logic [1:0] PAIR_CROSSED  = 2'b11;
    localparam logic [1:0] SPD_10        = 2'b00;
    localparam logic [1:0] SPD_100       = 2'b01;
    localparam logic [1:0] SPD_1000      = 2'b10;
    localparam logic [2:0] DS_BASE       = 3'd2;

    localparam logic [1:0] IPD_ST_SEARCH = 2'b00;
    localparam logic [1:0] IPD_ST_FOUND  = 2'b01;
    localparam logic [1:0] IPD_ST_NONE   = 2'b10;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ      = 40;
    localparam int IPD_LIMIT_US = 100;
    localparam int IPD_LIMIT_CYC = IPD_LIMIT_US * CLK_MHZ;

    typedef enum logic [2:0] {
        IPD_IDLE   = 3'b000,
        IPD_SEARCH = 3'b001,
        IPD_FOUND  = 3'b010,
        IPD_NEG    = 3'b011,
        IPD_UP     = 3'b100
    } clsc_ipd_state_type;

    // Cable-side observations, {1000F,1000H,100F,100H,10F,10H}
    typedef struct packed {
        logic        link_ok;
        logic        lp_an;
        logic        lp_ms;
        logic [5:0]  lp_abil;
        logic        pd_valid;
        logic [1:0]  pd_speed;
        logic        obs_cross;
        logic        obs_cdswap;
        logic [3:0]  obs_pol;
        logic        gig_fail;
        logic        loopback;
        logic [15:0] lp_np;
    } clsc_line_type;

    typedef struct packed {
        logic        an_on;
        logic [1:0]  speed;
        logic        full_dup;
        logic        master;
        logic [5:0]  adv;
        logic        crossed;
        logic        cd_swap;
        logic [3:0]  pol_fix;
        logic        send_ipd;
        logic [15:0] np_tx;
    } clsc_link_type;

endpackage : clsc_pkg

// File: rtl/clsc_ipd_fsm.sv
module clsc_ipd_fsm
    import clsc_pkg::*;
#(
    parameter int LIMIT_CYC = IPD_LIMIT_CYC
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       enable,
    input  wire logic       link_up,
    input  wire logic       loopback,
    // Status
    output logic [1:0]      status,
    output logic            sending,
    output logic            found,
    output logic            hold_an
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CW = $clog2(LIMIT_CYC + 1);
    localparam logic [CW-1:0] LIM = CW'(LIMIT_CYC - 1);

    typedef struct packed {
        clsc_ipd_state_type st;
        logic [CW-1:0]      cnt;
        logic [1:0]         status;
        logic               found;
    } clsc_ipd_reg_type;

    clsc_ipd_reg_type q, d;

    always_comb begin
        d = q;
        d.found = 1'b0;
        if (!enable) begin
            d.st = IPD_IDLE;
        end else begin
            case (q.st)
                IPD_IDLE: begin
                    d.st     = IPD_SEARCH;
                    d.cnt    = '0;
                    d.status = IPD_ST_SEARCH;
                end
                IPD_SEARCH: begin
                    d.cnt = q.cnt + 1'b1;
                    if (loopback) begin
                        d.st     = IPD_FOUND;
                        d.status = IPD_ST_FOUND;
                        d.found  = 1'b1;
                    end else if (q.cnt == LIM) begin
                        d.st     = IPD_NEG;
                        d.status = IPD_ST_NONE;
                    end
                end
                IPD_FOUND: begin
                    if (link_up) begin
                        d.st = IPD_UP;
                    end
                end
                IPD_NEG: begin
                    if (link_up) begin
                        d.st = IPD_UP;
                    end
                end
                IPD_UP: begin
                    if (!link_up) begin
                        d.st     = IPD_SEARCH;
                        d.cnt    = '0;
                        d.status = IPD_ST_SEARCH;
                    end
                end
                default: d.st = IPD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= '{st: IPD_IDLE, cnt: '0, status: IPD_ST_SEARCH, found: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign status  = q.status;
    assign found   = q.found;
    assign sending = (q.st == IPD_SEARCH);
    // Normal negotiation runs unless detection is still searching or has found a partner without a link
    assign hold_an = (q.st == IPD_SEARCH) || (q.st == IPD_FOUND);

endmodule : clsc_ipd_fsm

// File: rtl/clsc_top.sv
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
module clsc_top
    import clsc_pkg::*;
#(
    parameter int IPD_LIMIT = IPD_LIMIT_CYC
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          sys_rst,
    // Avalon-MM slave
    input  wire logic [6:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    // Cable side
    input  wire clsc_line_type line_in,
    output clsc_link_type      link_out,
    // Station interrupt
    output logic               mdint
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        clsc_line_type s1;
        clsc_line_type s2;
        logic          wait_q;
        logic [15:0]   rdata;
        logic [15:0]   ctl;
        logic [15:0]   adv;
        logic [15:0]   gadv;
        logic [15:0]   nptx;
        logic [15:0]   mdix;
        logic [15:0]   inten;
        logic [15:0]   page;
        logic          int_pend;
        logic          ds_en;
        logic [1:0]    ds_cnt;
        logic          downshifted;
        logic [2:0]    fail_cnt;
        logic          fail_prev;
        logic          ipd_en;
        logic          fx_dis;
        logic [1:0]    pair_force;
        logic          link_stat;
        clsc_link_type lo;
        logic          mdint;
    } clsc_top_type;

    clsc_top_type q, d;

    logic [1:0] ipd_status;
    logic       ipd_send;
    logic       ipd_found;
    logic       ipd_hold;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) r[7:0] = wd[7:0];
        if (be[1]) r[15:8] = wd[15:8];
        return r;
    endfunction : merge

    // Highest common ability: {speed, full duplex}
    function automatic logic [2:0] resolve(input logic [5:0] c);
        logic [2:0] r;
        r = {SPD_10, 1'b0};
        if (c[5]) r = {SPD_1000, 1'b1};
        else if (c[4]) r = {SPD_1000, 1'b0};
        else if (c[3]) r = {SPD_100, 1'b1};
        else if (c[2]) r = {SPD_100, 1'b0};
        else if (c[1]) r = {SPD_10, 1'b1};
        return r;
    endfunction : resolve

    // ----------------------------------------------------------------
    // Unpowered-partner detection
    // ----------------------------------------------------------------
    clsc_ipd_fsm #(
        .LIMIT_CYC (IPD_LIMIT)
    ) u_ipd (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .enable   (q.ipd_en && q.ctl[CTL_AN_EN]),
        .link_up  (q.s2.link_ok),
        .loopback (q.s2.loopback),
        .status   (ipd_status),
        .sending  (ipd_send),
        .found    (ipd_found),
        .hold_an  (ipd_hold)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic        req;
    logic        take;
    logic [4:0]  idx;
    logic        on_main;
    logic        on_ext;
    logic        on_test;
    logic [15:0] rd_val;
    logic [15:0] wv;
    logic        clr_int;
    logic        restart;
    logic [5:0]  own_abil;
    logic [2:0]  res;
    logic        auto_ok;
    logic        fail_edge;

    always_comb begin
        d         = q;
        req       = avs_read || avs_write;
        take      = req && !q.wait_q;
        idx       = avs_address[6:2];
        on_main   = (q.page == PAGE_MAIN);
        on_ext    = (q.page == PAGE_EXT);
        on_test   = (q.page == PAGE_TEST);
        clr_int   = 1'b0;
        restart   = 1'b0;
        wv        = '0;
        res       = '0;
        fail_edge = 1'b0;

        // Two-stage synchroniser for all cable-side inputs
        d.s1 = line_in;
        d.s2 = q.s1;

        // Read mux, unmapped reads as zero
        rd_val = '0;
        if (idx == REG_PAGE) begin
            rd_val = q.page;
        end else if (on_main && idx == REG_CTL) begin
            rd_val = q.ctl;
        end else if (on_main && idx == REG_STAT) begin
            rd_val = STAT_BASE;
            rd_val[STAT_LINK] = q.link_stat;
        end else if (on_main && idx == REG_ADV) begin
            rd_val = q.adv;
        end else if (on_main && idx == REG_NPTX) begin
            rd_val = q.nptx;
        end else if (on_main && idx == REG_NPRX) begin
            rd_val = q.s2.lp_np;
        end else if (on_main && idx == REG_GADV) begin
            rd_val = q.gadv;
        end else if (on_main && idx == REG_MDIX) begin
            rd_val = q.mdix;
        end else if (on_main && idx == REG_INTEN) begin
            rd_val = q.inten;
        end else if (on_main && idx == REG_INTST) begin
            rd_val[INT_IPD] = q.int_pend;
        end else if (on_main && idx == REG_AUXST) begin
            rd_val = {2'b00, q.lo.crossed, q.lo.cd_swap, q.lo.pol_fix, 2'b00,
                      q.lo.full_dup, q.lo.speed, 3'b000};
        end else if (on_ext && idx == REG_DSHIFT) begin
            rd_val[DS_EN] = q.ds_en;
            rd_val[DS_CNT_LSB +: 2] = q.ds_cnt;
            rd_val[DS_STAT] = q.downshifted;
        end else if (on_ext && idx == REG_IPD) begin
            rd_val[IPD_EN] = q.ipd_en;
            rd_val[IPD_ST_LSB +: 2] = ipd_status;
        end else if (on_ext && idx == REG_FXMDIX) begin
            rd_val[FX_MDIX_DIS] = q.fx_dis;
        end else if (on_test && idx == REG_PAIR) begin
            rd_val[PAIR_LSB +: 2] = q.pair_force;
        end

        // Bus: one wait cycle, then waitrequest low for one cycle
        if (!q.wait_q) begin
            d.wait_q = 1'b1;
        end else if (req) begin
            d.wait_q = 1'b0;
            d.rdata  = rd_val;
        end

        // Effects land on the edge that completes the transfer
        if (take && avs_read && on_main && idx == REG_INTST) begin
            clr_int = 1'b1;
        end
        if (take && avs_write) begin
            if (idx == REG_PAGE) begin
                wv = merge(q.page, avs_writedata, avs_byteenable);
                d.page = wv;
            end else if (on_main && idx == REG_CTL) begin
                wv = merge(q.ctl, avs_writedata, avs_byteenable);
                restart = wv[CTL_AN_RST];
                wv[CTL_AN_RST] = 1'b0;
                d.ctl = wv;
            end else if (on_main && idx == REG_ADV) begin
                d.adv = merge(q.adv, avs_writedata, avs_byteenable);
            end else if (on_main && idx == REG_NPTX) begin
                d.nptx = merge(q.nptx, avs_writedata, avs_byteenable);
            end else if (on_main && idx == REG_GADV) begin
                d.gadv = merge(q.gadv, avs_writedata, avs_byteenable);
            end else if (on_main && idx == REG_MDIX) begin
                d.mdix = merge(q.mdix, avs_writedata, avs_byteenable);
            end else if (on_main && idx == REG_INTEN) begin
                d.inten = merge(q.inten, avs_writedata, avs_byteenable);
            end else if (on_ext && idx == REG_DSHIFT) begin
                wv = merge(16'h0000, avs_writedata, avs_byteenable);
                d.ds_en  = wv[DS_EN];
                d.ds_cnt = wv[DS_CNT_LSB +: 2];
            end else if (on_ext && idx == REG_IPD) begin
                wv = merge(16'h0000, avs_writedata, avs_byteenable);
                d.ipd_en = wv[IPD_EN];
            end else if (on_ext && idx == REG_FXMDIX) begin
                wv = merge(16'h0000, avs_writedata, avs_byteenable);
                d.fx_dis = wv[FX_MDIX_DIS];
            end else if (on_test && idx == REG_PAIR) begin
                wv = merge(16'h0000, avs_writedata, avs_byteenable);
                d.pair_force = wv[PAIR_LSB +: 2];
            end
        end

        // Set wins over clear-on-read
        d.int_pend = (q.int_pend && !clr_int) || ipd_found;
        d.mdint    = d.int_pend && q.inten[INT_PIN_EN];

        // Downshift: count failed gigabit attempts on rising edges
        fail_edge   = q.s2.gig_fail && !q.fail_prev;
        d.fail_prev = q.s2.gig_fail;
        if (restart || !q.ctl[CTL_AN_EN] || !q.ds_en) begin
            d.fail_cnt    = '0;
            d.downshifted = 1'b0;
        end else if (fail_edge && !q.downshifted && q.lo.adv[ABIL_GIG_LSB +: 2] != 2'b00) begin
            d.fail_cnt = q.fail_cnt + 1'b1;
            if (d.fail_cnt >= DS_BASE + {1'b0, q.ds_cnt}) begin
                d.downshifted = 1'b1;
            end
        end

        // Advertisement, gigabit dropped once downshifted
        own_abil = {q.gadv[GADV_1000F] && !q.downshifted, q.gadv[GADV_1000H] && !q.downshifted,
                    q.adv[ADV_ABIL_LSB +: 4]};
        d.lo.adv   = own_abil;
        d.lo.np_tx = q.nptx;
        d.lo.an_on = q.ctl[CTL_AN_EN] && !ipd_hold;
        d.lo.send_ipd = ipd_send;

        // Operating mode
        if (!q.ctl[CTL_AN_EN]) begin
            d.lo.speed    = {q.ctl[CTL_SPD_MSB], q.ctl[CTL_SPD_LSB]};
            d.lo.full_dup = q.ctl[CTL_DUPLEX];
        end else if (q.s2.lp_an) begin
            res = resolve(own_abil & q.s2.lp_abil);
            d.lo.speed    = res[2:1];
            d.lo.full_dup = res[0];
        end else if (q.s2.pd_valid) begin
            d.lo.speed    = q.s2.pd_speed;
            d.lo.full_dup = 1'b0;
        end
        if (q.gadv[GADV_MS_MAN]) begin
            d.lo.master = q.gadv[GADV_MS_VAL];
        end else begin
            d.lo.master = !q.s2.lp_ms;
        end

        // Pair mapping and polarity
        auto_ok = q.ctl[CTL_AN_EN] || (d.lo.speed != SPD_1000 && !q.fx_dis);
        if (q.pair_force == PAIR_STRAIGHT) begin
            d.lo.crossed = 1'b0;
            d.lo.cd_swap = 1'b0;
        end else if (q.pair_force == PAIR_CROSSED) begin
            d.lo.crossed = 1'b1;
            d.lo.cd_swap = 1'b0;
        end else if (!q.mdix[MDIX_AUTOD] && auto_ok) begin
            d.lo.crossed = q.s2.obs_cross;
            d.lo.cd_swap = q.s2.obs_cdswap;
        end else begin
            d.lo.crossed = q.mdix[MDIX_XSEL];
            d.lo.cd_swap = 1'b0;
        end
        d.lo.pol_fix = q.mdix[MDIX_POLD] ? 4'h0 : q.s2.obs_pol;

        d.link_stat = q.s2.link_ok && !ipd_hold;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q            <= '0;
            q.wait_q     <= 1'b1;
            q.ctl        <= CTL_RST;
            q.adv        <= ADV_RST;
            q.gadv       <= GADV_RST;
            q.nptx       <= NPTX_RST;
        end else begin
            q <= d;
        end
    end

    assign avs_waitrequest = q.wait_q;
    assign avs_readdata    = {16'h0000, q.rdata};
    assign link_out        = q.lo;
    assign mdint           = q.mdint;

endmodule : clsc_top

// File: dv/clsc_top_assertions.sv
module clsc_top_checker
    import clsc_pkg::*;
(
    // Clock and reset
    input wire logic          core_clk,
    input wire logic          sys_rst,
    // Register bus
    input wire logic [6:0]    avs_address,
    input wire logic          avs_read,
    input wire logic          avs_write,
    input wire logic [31:0]   avs_writedata,
    input wire logic [31:0]   avs_readdata,
    input wire logic          avs_waitrequest,
    // Cable side and interrupt
    input wire clsc_link_type link_out,
    input wire logic          mdint
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pg_q;
    logic [15:0] ctl_q;
    logic        ien_q;
    // --------------------------------
    // Shadow of the bits under test
    // --------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pg_q  <= PAGE_MAIN;
            ctl_q <= CTL_RST;
            ien_q <= 1'b0;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address[6:2] == REG_PAGE) pg_q <= avs_writedata[15:0];
            if (pg_q == PAGE_MAIN && avs_address[6:2] == REG_CTL) ctl_q <= avs_writedata[15:0];
            if (pg_q == PAGE_MAIN && avs_address[6:2] == REG_INTEN) ien_q <= avs_writedata[INT_PIN_EN];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_req_taken: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    a_rd_page: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000
        && (!(avs_read && avs_address[6:2] == REG_PAGE) || avs_readdata[15:0] == pg_q))
        else $error("read data upper half or page select wrong");
    a_pin_gate: assert property (mdint |-> ien_q || $past(ien_q))
        else $error("interrupt pin driven while disabled");
    a_an_off: assert property (!ctl_q[CTL_AN_EN] && !$past(ctl_q[CTL_AN_EN], 4)
        |-> !link_out.an_on && !link_out.send_ipd)
        else $error("negotiation or detection active while disabled");
    a_forced_mode: assert property (!ctl_q[CTL_AN_EN] && $past(ctl_q, 4) == ctl_q
        |-> link_out.speed == {ctl_q[CTL_SPD_MSB], ctl_q[CTL_SPD_LSB]} && link_out.full_dup == ctl_q[CTL_DUPLEX])
        else $error("forced speed or duplex not applied");
    a_search_quiet: assert property (link_out.send_ipd |-> !link_out.an_on)
        else $error("negotiation running during detection");
endmodule : clsc_top_checker

bind clsc_top clsc_top_checker i_chk (.*);

// File: dv/clsc_line_model.sv
module clsc_line_model
    import clsc_pkg::*;
(
    // Clock
    input wire logic    core_clk,
    // Scenario controls
    input wire logic    loop_on,
    input wire logic    link_on,
    input wire logic    cross_on,
    // Cable observations
    output clsc_line_type line
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge core_clk) begin
        line.lp_an      <= 1'b1;
        line.lp_ms      <= 1'b0;
        line.lp_abil    <= 6'b00_1111;
        line.pd_valid   <= 1'b0;
        line.pd_speed   <= SPD_10;
        line.link_ok    <= link_on;
        line.loopback   <= loop_on;  // Unpowered partner echoes pulses
        line.obs_cross  <= cross_on;
        line.obs_cdswap <= 1'b0;
        line.obs_pol    <= 4'b0101;
        line.gig_fail   <= 1'b0;
        line.lp_np      <= 16'h5a5a;
    end
endmodule : clsc_line_model

// File: dv/clsc_top_bench.sv
module clsc_top_bench
    import clsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest, mdint;
    logic [6:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic loop_on = 0, link_on = 0, cross_on = 1;
    logic [15:0] rv;
    clsc_line_type line_in;
    clsc_link_type link_out;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    logic [4:0] ri [6] = '{REG_CTL, REG_ADV, REG_GADV, REG_NPTX, REG_MDIX, 5'd2};
    logic [15:0] rx [6] = '{CTL_RST, ADV_RST, GADV_RST, NPTX_RST, 16'h0000, 16'h0000};
    always #12.5 core_clk = ~core_clk;
    clsc_top #(.IPD_LIMIT(20)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_in(line_in),
        .link_out(link_out), .mdint(mdint));
    clsc_line_model i_lp (.core_clk(core_clk), .loop_on(loop_on), .link_on(link_on), .cross_on(cross_on),
        .line(line_in));
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Held until the edge that sees waitrequest low
    task bus(input logic wr, input logic [4:0] idx, input logic [15:0] wd);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {16'h0000, wd};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rv = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task rdc(input logic [4:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk(rv, exp);
    endtask : rdc
    task gap;
        repeat (6) @(posedge core_clk);
    endtask : gap
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) rdc(ri[i], rx[i]);
        rdc(REG_NPRX, 16'h5a5a);
        bus(1'b1, REG_CTL, 16'h2100);
        gap();
        chk({link_out.an_on, link_out.speed, link_out.full_dup}, {1'b0, SPD_100, 1'b1});
        chk(link_out.crossed, 1'b1);
        bus(1'b1, REG_PAGE, PAGE_EXT);
        bus(1'b1, REG_FXMDIX, 16'h8000);
        bus(1'b1, REG_PAGE, PAGE_MAIN);
        gap();
        chk(link_out.crossed, 1'b0);
        bus(1'b1, REG_CTL, CTL_RST);
        bus(1'b1, REG_PAGE, PAGE_TEST);
        rdc(REG_PAGE, PAGE_TEST);
        bus(1'b1, REG_PAIR, 16'h0010);
        bus(1'b1, REG_PAGE, PAGE_MAIN);
        gap();
        chk(link_out.crossed, 1'b0);
        bus(1'b1, REG_PAGE, PAGE_TEST);
        bus(1'b1, REG_PAIR, 16'h0018);
        bus(1'b1, REG_PAGE, PAGE_MAIN);
        gap();
        chk({link_out.crossed, link_out.cd_swap}, 2'b10);
        bus(1'b1, REG_PAGE, PAGE_TEST);
        bus(1'b1, REG_PAIR, 16'h0000);
        bus(1'b1, REG_PAGE, PAGE_MAIN);
        gap();
        chk(link_out.crossed, 1'b1);
        chk(link_out.pol_fix, 4'b0101);
        chk({link_out.an_on, link_out.speed, link_out.full_dup}, {1'b1, SPD_100, 1'b1});
        chk({link_out.master, link_out.adv, link_out.np_tx}, {1'b1, 6'h3f, NPTX_RST});
        bus(1'b1, REG_INTEN, 16'h8000);
        bus(1'b1, REG_PAGE, PAGE_EXT);
        bus(1'b1, REG_IPD, 16'h0400);
        rdc(REG_IPD, 16'h0400);
        chk(link_out.send_ipd, 1'b1);
        loop_on <= 1'b1;
        gap();
        rdc(REG_IPD, 16'h0500);
        bus(1'b1, REG_PAGE, PAGE_MAIN);
        chk(mdint, 1'b1);
        rdc(REG_INTST, 16'h0200);
        rdc(REG_INTST, 16'h0000);
        chk(mdint, 1'b0);
        link_on <= 1'b1;
        gap();
        link_on <= 1'b0;
        loop_on <= 1'b0;
        bus(1'b1, REG_PAGE, PAGE_EXT);
        repeat (40) @(posedge core_clk);
        rdc(REG_IPD, 16'h0600);
        chk({link_out.an_on, link_out.send_ipd}, 2'b10);
        link_on <= 1'b1;
        gap();
        bus(1'b1, REG_PAGE, PAGE_MAIN);
        rdc(REG_STAT, STAT_BASE | 16'h0004);
        bus(1'b1, REG_PAGE, PAGE_EXT);
        link_on <= 1'b0;
        repeat (4) @(posedge core_clk);
        rdc(REG_IPD, 16'h0400);
        give_verdict();
    end
endmodule : clsc_top_bench
